/* File: logic/tlc_logger.sv */
`timescale 1ns/1ps
`include "tlc_regs.svh"
module tlc_logger
    import tlc_pkg::*;
#(
    parameter int TICK_DIV = `TLC_TICK_DIV,
    parameter int HOLD_TICKS = `TLC_HOLD_TICKS,
    parameter int SEC_TICKS = `TLC_TICK_HZ,
    parameter logic [63:0] SERIAL_NUMBER = 64'h0123456789ABCDEF
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic interface_select,
    input wire logic [12:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    output logic [15:0] readCrc,
    output logic syncActive,
    output logic asyncActive,
    input wire logic [7:0] sensorTemp,
    input wire logic start_button_n,
    output logic interrupt_n,
    output logic within_limits_n,
    output logic beyond_limits_n
);
    // serial number value is arbitrary
    logic [2:0] selSync;
    logic [2:0] btnSync;
    logic selStable;
    logic btnLow;
    logic [15:0] divCnt;
    logic tick;
    logic [15:0] secCnt;
    logic secPulse;
    logic [7:0] sec, min, hour, dow, date, mon, year;
    logic [7:0] tHigh, tLow, rate, ctrl, tempReg, cmdLast;
    logic [15:0] startDelay;
    logic thf, tlf;
    logic [7:0] userMem [0:31];
    logic [7:0] logMem [0:`TLC_LOG_DEPTH-1];
    logic [15:0] histMem [0:`TLC_HIST_BINS-1];
    logic [11:0] logCount;
    logic [14:0] holdCnt;
    logic holdDone;
    tlc_mission_e mission, next_mission;
    logic [7:0] minCnt;
    logic [15:0] delayCnt;
    logic minPulse;
    logic sampleNow;
    logic [5:0] binIdx;
    logic [7:0] page;
    logic [4:0] off;
    logic ctrlWr;
    logic cmdStart;
    logic btnStart;
    logic btnPress;
    logic btnPrev;
    logic reportOn;
    logic [7:0] rdByte;
    logic [15:0] crcNext;

    // pins from outside pass three flops; stable when last two agree
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            selSync <= 3'h0;
            btnSync <= 3'h7;
            selStable <= 1'b0;
            btnLow <= 1'b0;
        end else begin
            selSync <= {selSync[1:0], interface_select};
            btnSync <= {btnSync[1:0], start_button_n};
            if (selSync[2] == selSync[1])
                selStable <= selSync[2];
            if (btnSync[2] == btnSync[1])
                btnLow <= ~btnSync[2];
        end
    end

    assign syncActive = selStable;
    assign asyncActive = ~selStable;

    // timebase stands in for the 32.768 kHz crystal
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt <= 16'h0000;
            tick <= 1'b0;
        end else begin
            tick <= (divCnt == 16'(TICK_DIV - 1));
            divCnt <= (divCnt == 16'(TICK_DIV - 1)) ? 16'h0000
                : divCnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            secCnt <= 16'h0000;
            secPulse <= 1'b0;
        end else begin
            secPulse <= tick && (secCnt == 16'(SEC_TICKS - 1));
            if (tick)
                secCnt <= (secCnt == 16'(SEC_TICKS - 1)) ? 16'h0000
                    : secCnt + 16'h0001;
        end
    end

    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0}
            : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] monthEnd(input logic [7:0] m,
                                            input logic [7:0] y);
        logic leap;
        leap = ({y[4], y[1:0]} == 3'b000) || ({y[4], y[1:0]} == 3'b110);
        case (m)
            8'h02: monthEnd = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: monthEnd = 8'h30;
            default: monthEnd = 8'h31;
        endcase
    endfunction

    assign off = regAddr[4:0];
    assign page = regAddr[12:5];
    assign ctrlWr = regWr && (page == `TLC_PG_CTRL);

    // calendar; 24-hour mode only, host write overrides the carry
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sec <= 8'h00;
            min <= 8'h00;
            hour <= 8'h00;
            dow <= 8'h01;
            date <= 8'h01;
            mon <= 8'h01;
            year <= 8'h00;
            minPulse <= 1'b0;
        end else begin
            minPulse <= 1'b0;
            if (ctrlWr && off <= `TLC_OFF_YEAR) begin
                case (off)
                    `TLC_OFF_SEC: sec <= regWrData;
                    `TLC_OFF_MIN: min <= regWrData;
                    `TLC_OFF_HOUR: hour <= regWrData;
                    `TLC_OFF_DOW: dow <= regWrData;
                    `TLC_OFF_DATE: date <= regWrData;
                    `TLC_OFF_MON: mon <= regWrData;
                    default: year <= regWrData;
                endcase
            end else if (secPulse) begin
                sec <= bcdInc(sec);
                if (sec == 8'h59) begin
                    sec <= 8'h00;
                    min <= bcdInc(min);
                    minPulse <= 1'b1;
                    if (min == 8'h59) begin
                        min <= 8'h00;
                        hour <= bcdInc(hour);
                        if (hour == 8'h23) begin
                            hour <= 8'h00;
                            dow <= (dow == 8'h07) ? 8'h01 : dow + 8'h01;
                            date <= bcdInc(date);
                            if (date == monthEnd(mon, year)) begin
                                date <= 8'h01;
                                mon <= bcdInc(mon);
                                if (mon == 8'h12) begin
                                    mon <= 8'h01;
                                    year <= bcdInc(year);
                                    if (year == 8'h99)
                                        year <= 8'h00;
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // control registers and user memory
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tHigh <= 8'hFF;
            tLow <= 8'h00;
            rate <= 8'h01;
            ctrl <= 8'h00;
            startDelay <= 16'h0000;
            cmdLast <= 8'h00;
        end else begin
            cmdLast <= 8'h00;
            if (ctrlWr) begin
                case (off)
                    `TLC_OFF_THI: tHigh <= regWrData;
                    `TLC_OFF_TLO: tLow <= regWrData;
                    `TLC_OFF_RATE: rate <= regWrData;
                    `TLC_OFF_CTRL: ctrl <= regWrData;
                    `TLC_OFF_DLY_L: startDelay[7:0] <= regWrData;
                    `TLC_OFF_DLY_H: startDelay[15:8] <= regWrData;
                    `TLC_OFF_CMD: cmdLast <= regWrData;
                    default: cmdLast <= 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (regWr && page == `TLC_PG_USER)
            userMem[off] <= regWrData;
    end

    assign cmdStart = (cmdLast == `TLC_CMD_START);

    // hold counter in timebase ticks; release before count restarts it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            holdCnt <= 15'h0000;
            holdDone <= 1'b0;
            btnPrev <= 1'b0;
        end else begin
            btnPrev <= holdDone;
            if (!btnLow) begin
                holdCnt <= 15'h0000;
                holdDone <= 1'b0;
            end else if (tick && !holdDone) begin
                holdCnt <= holdCnt + 15'h0001;
                if (holdCnt == 15'(HOLD_TICKS - 1))
                    holdDone <= 1'b1;
            end
        end
    end

    assign btnPress = holdDone && !btnPrev;
    assign btnStart = btnPress && ctrl[`TLC_CTRL_SE];

    always_comb begin
        next_mission = mission;
        case (mission)
            TLC_IDLE: begin
                if (btnStart || cmdStart)
                    next_mission = (startDelay == 16'h0000) ? TLC_RUN
                        : TLC_DELAY;
            end
            TLC_DELAY: begin
                if (minPulse && delayCnt == 16'h0001)
                    next_mission = TLC_RUN;
            end
            TLC_RUN: next_mission = TLC_RUN;
            default: next_mission = TLC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mission <= TLC_IDLE;
            delayCnt <= 16'h0000;
            minCnt <= 8'h00;
        end else begin
            mission <= next_mission;
            if (mission == TLC_IDLE)
                delayCnt <= startDelay;
            else if (mission == TLC_DELAY && minPulse)
                delayCnt <= delayCnt - 16'h0001;
            if (mission != TLC_RUN)
                minCnt <= 8'h00;
            else if (minPulse)
                minCnt <= (minCnt + 8'h01 >= rate) ? 8'h00
                    : minCnt + 8'h01;
        end
    end

    // rate of zero behaves as one minute
    assign sampleNow = (mission == TLC_RUN) && minPulse
        && (minCnt + 8'h01 >= rate);

    // half degrees in eight bits top out below +85 C; clamp low end only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            tempReg <= 8'h00;
        else if (sampleNow) begin
            if ($signed(sensorTemp) < $signed(8'hB0))
                tempReg <= 8'hB0;
            else
                tempReg <= sensorTemp;
        end
    end

    // bin of 2 C is four half-degree steps, offset from -40 C
    assign binIdx = 6'((8'(tempReg + 8'h50)) >> 2);

    logic logWrite;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            logWrite <= 1'b0;
        else
            logWrite <= sampleNow;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            logCount <= 12'h000;
        else if (logWrite && logCount != 12'(`TLC_LOG_DEPTH))
            logCount <= logCount + 12'h001;
    end

    always_ff @(posedge sys_clk) begin
        if (logWrite && logCount != 12'(`TLC_LOG_DEPTH))
            logMem[logCount[10:0]] <= tempReg;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `TLC_HIST_BINS; gi++) begin : gHist
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b)
                    histMem[gi] <= 16'h0000;
                else if (logWrite && binIdx == 6'(gi)
                         && histMem[gi] != 16'hFFFF)
                    histMem[gi] <= histMem[gi] + 16'h0001;
            end
        end
    endgenerate

    // flags are sticky until software writes zero; sample wins
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            thf <= 1'b0;
            tlf <= 1'b0;
        end else begin
            if (logWrite && $signed(tempReg) > $signed(tHigh))
                thf <= 1'b1;
            else if (ctrlWr && off == `TLC_OFF_STAT)
                thf <= regWrData[`TLC_STAT_THF];
            if (logWrite && $signed(tempReg) < $signed(tLow))
                tlf <= 1'b1;
            else if (ctrlWr && off == `TLC_OFF_STAT)
                tlf <= regWrData[`TLC_STAT_TLF];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            interrupt_n <= 1'b1;
        else
            interrupt_n <= !((thf && ctrl[`TLC_CTRL_THIE])
                || (tlf && ctrl[`TLC_CTRL_TLIE]));
    end

    // status shows only while the button is held after the mission started
    assign reportOn = (mission != TLC_IDLE) && btnLow;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            within_limits_n <= 1'b1;
            beyond_limits_n <= 1'b1;
        end else begin
            within_limits_n <= !(reportOn && !(thf || tlf));
            beyond_limits_n <= !(reportOn && (thf || tlf));
        end
    end

    // read decode; reserved pages and offsets read zero
    always_comb begin
        rdByte = 8'h00;
        if (page == `TLC_PG_CTRL) begin
            case (off)
                `TLC_OFF_SEC: rdByte = sec;
                `TLC_OFF_MIN: rdByte = min;
                `TLC_OFF_HOUR: rdByte = hour;
                `TLC_OFF_DOW: rdByte = dow;
                `TLC_OFF_DATE: rdByte = date;
                `TLC_OFF_MON: rdByte = mon;
                `TLC_OFF_YEAR: rdByte = year;
                `TLC_OFF_THI: rdByte = tHigh;
                `TLC_OFF_TLO: rdByte = tLow;
                `TLC_OFF_RATE: rdByte = rate;
                `TLC_OFF_CTRL: rdByte = ctrl;
                `TLC_OFF_TEMP: rdByte = tempReg;
                `TLC_OFF_DLY_L: rdByte = startDelay[7:0];
                `TLC_OFF_DLY_H: rdByte = startDelay[15:8];
                `TLC_OFF_STAT: rdByte = {2'b00, mission == TLC_RUN,
                    mission == TLC_DELAY, 1'b0, tlf, thf, 1'b0};
                default: rdByte = 8'h00;
            endcase
        end else if (page == `TLC_PG_USER) begin
            rdByte = userMem[off];
        end else if (page == `TLC_PG_SER && off >= 5'h18) begin
            rdByte = SERIAL_NUMBER[{off[2:0], 3'b000} +: 8];
        end else if (page >= `TLC_PG_HIST_LO && page <= `TLC_PG_HIST_HI
                     && regAddr[6:1] < 6'(`TLC_HIST_BINS)) begin
            rdByte = regAddr[0] ? histMem[regAddr[6:1]][15:8]
                : histMem[regAddr[6:1]][7:0];
        end else if (page >= `TLC_PG_LOG_LO && page <= `TLC_PG_LOG_HI) begin
            rdByte = logMem[regAddr[10:0]];
        end else begin
            rdByte = 8'h00;
        end
    end

    // alarm stamp pages decode but hold no events here and read zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            regRdData <= 8'h00;
        else if (regRd)
            regRdData <= rdByte;
    end

    always_comb begin
        crcNext = readCrc;
        for (int i = 0; i < 8; i++)
            crcNext = (crcNext[15] ^ rdByte[i])
                ? ((crcNext << 1) ^ `TLC_CRC_POLY) : (crcNext << 1);
    end

    // crc runs over bytes read in async mode; cleared by a write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            readCrc <= 16'h0000;
        else if (regWr)
            readCrc <= 16'h0000;
        else if (regRd && asyncActive)
            readCrc <= crcNext;
    end
endmodule

/* File: pkg/tlc_regs.svh */
`ifndef TLC_REGS_SVH
`define TLC_REGS_SVH
// Contract
// - select high: use synchronous three-wire pins only
// - select low: use asynchronous tx/rx pins
// - interrupt low while enabled flag set
// - button start needs 0.5 s low hold
// - press after start reports limit status
// - sample every 1 to 255 minutes
// - datalog written in sequence, 2048 maximum
// - histogram bin counter increments, 63 bins
// - readings 0.5 C steps, -40 to +85; code clamps at -40 but tops out at +63.5
// - compare samples with high and low limits
// - host command can start the mission
// - linear space in 32-byte pages
// - decode clock, user, alarm, histogram, datalog pages; code stores no alarm stamps, those pages read zero
// - other pages reserved, read zero
// - writes only to control and user pages
// - BCD calendar with leap years
// - async mode: 16-bit CRC on reads
// - read-only 64-bit serial number
// - 96 alarm, 128 histogram, 2048 datalog bytes
`define TLC_ADDR_W 13
`define TLC_PAGE_SHIFT 5
`define TLC_PG_CTRL 8'h00
`define TLC_PG_USER 8'h02
`define TLC_PG_SER 8'h10
`define TLC_PG_ALM_LO 8'h11
`define TLC_PG_ALM_HI 8'h13
`define TLC_PG_HIST_LO 8'h40
`define TLC_PG_HIST_HI 8'h43
`define TLC_PG_LOG_LO 8'h80
`define TLC_PG_LOG_HI 8'hBF
`define TLC_SER_BASE 13'h0218
`define TLC_OFF_SEC 5'h00
`define TLC_OFF_MIN 5'h01
`define TLC_OFF_HOUR 5'h02
`define TLC_OFF_DOW 5'h03
`define TLC_OFF_DATE 5'h04
`define TLC_OFF_MON 5'h05
`define TLC_OFF_YEAR 5'h06
`define TLC_OFF_THI 5'h0B
`define TLC_OFF_TLO 5'h0C
`define TLC_OFF_RATE 5'h0D
`define TLC_OFF_CTRL 5'h0E
`define TLC_OFF_TEMP 5'h11
`define TLC_OFF_DLY_L 5'h12
`define TLC_OFF_DLY_H 5'h13
`define TLC_OFF_STAT 5'h14
`define TLC_OFF_CMD 5'h1F
`define TLC_CMD_START 8'hA5
`define TLC_CTRL_SE 4
`define TLC_CTRL_TLIE 2
`define TLC_CTRL_THIE 1
`define TLC_STAT_MIP 5
`define TLC_STAT_TLF 2
`define TLC_STAT_THF 1
`define TLC_LOG_DEPTH 2048
`define TLC_HIST_BINS 63
`define TLC_CLK_HZ 250000000
`define TLC_TICK_HZ 32768
`define TLC_TICK_DIV (`TLC_CLK_HZ / `TLC_TICK_HZ)
`define TLC_HOLD_MS 500
`define TLC_HOLD_TICKS ((`TLC_TICK_HZ * `TLC_HOLD_MS + 999) / 1000)
`define TLC_CRC_POLY 16'h8005
`endif

/* File: pkg/tlc_pkg.sv */
package tlc_pkg;
    typedef enum logic [1:0] {
        TLC_IDLE = 2'b00,
        TLC_DELAY = 2'b01,
        TLC_RUN = 2'b10
    } tlc_mission_e;
endpackage

/* File: verification/tlc_logger_props.sv */
`timescale 1ns/1ps
module tlc_logger_props #(
    parameter logic [63:0] SERIAL_NUMBER = 64'h0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic interface_select,
    input wire logic [12:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic [15:0] readCrc,
    input wire logic syncActive,
    input wire logic asyncActive,
    input wire logic [7:0] sensorTemp,
    input wire logic start_button_n,
    input wire logic interrupt_n,
    input wire logic within_limits_n,
    input wire logic beyond_limits_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] lastByte;
    logic rsvd;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lastByte <= 3'h0;
        end else begin
            lastByte <= regAddr[2:0];
        end
    end
    // page 16 is left out: its top eight bytes hold the serial number
    assign rsvd = regAddr[12:5] inside {8'h01, [8'h03:8'h0F],
        [8'h14:8'h3F], [8'h44:8'h7F], [8'hC0:8'hFF]};
    a_sync_link: assert property (interface_select [*5] |-> syncActive && !asyncActive) else $error("sync link not chosen");
    a_async_link: assert property (!interface_select [*5] |-> asyncActive && !syncActive) else $error("async link not chosen");
    a_one_link: assert property (syncActive != asyncActive) else $error("link choice not exclusive");
    a_read_hold: assert property (!regRd |=> $stable(regRdData)) else $error("read data moved without a read");
    a_crc_hold: assert property (!(regRd && asyncActive) && !regWr |=> $stable(readCrc)) else $error("crc moved without an async read");
    a_rsvd_zero: assert property (regRd && rsvd |=> regRdData == 8'h00) else $error("reserved page read not zero");
    a_serial_read: assert property (regRd && regAddr[12:3] == 10'h043 |=> regRdData == SERIAL_NUMBER[{lastByte, 3'b000} +: 8]) else $error("serial byte wrong");
    a_user_back: assert property (regWr && regAddr[12:5] == 8'h02 ##2 regRd && regAddr == $past(regAddr, 2) |=> regRdData == $past(regWrData, 3)) else $error("user byte not read back");
    a_pins_rest: assert property (start_button_n [*6] |-> within_limits_n && beyond_limits_n) else $error("status pins low with button up");
    a_pins_one: assert property (!within_limits_n |-> beyond_limits_n) else $error("both status pins low");
    c_cmd: cover property (regWr && regAddr == 13'h001F && regWrData == 8'hA5);
    c_int: cover property ($fell(interrupt_n));
    c_beyond: cover property (!beyond_limits_n);
endmodule
bind tlc_logger tlc_logger_props #(.SERIAL_NUMBER(SERIAL_NUMBER)) u_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .interface_select(interface_select),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .readCrc(readCrc), .syncActive(syncActive),
    .asyncActive(asyncActive), .sensorTemp(sensorTemp),
    .start_button_n(start_button_n), .interrupt_n(interrupt_n),
    .within_limits_n(within_limits_n), .beyond_limits_n(beyond_limits_n)
);

/* File: verification/tlc_env_model.sv */
`timescale 1ns/1ps
module tlc_env_model (
    input wire logic sys_clk,
    input wire logic [7:0] tempReq,
    input wire logic [7:0] pressLen,
    input wire logic pressGo,
    output logic [7:0] sensorTemp,
    output logic start_button_n
);
    logic [7:0] holdLeft;
    initial begin
        holdLeft = 8'h00;
        sensorTemp = 8'h00;
    end
    // pull-up on the pin: a released button reads high
    assign start_button_n = holdLeft == 8'h00;
    always @(posedge sys_clk) begin
        sensorTemp <= tempReq;
        if (pressGo) begin
            holdLeft <= pressLen;
        end else if (holdLeft != 8'h00) begin
            holdLeft <= holdLeft - 8'h01;
        end
    end
endmodule

/* File: verification/tlc_logger_bench.sv */
`timescale 1ns/1ps
`include "tlc_regs.svh"
module tlc_logger_bench
    import tlc_pkg::*;
;
    localparam logic [63:0] SER = 64'h5A3C96E10F7824BD; // arbitrary value
    logic sys_clk, rst_b, interface_select, regWr, regRd, rdChk, rdLate;
    logic pressGo, syncActive, asyncActive, start_button_n, interrupt_n;
    logic within_limits_n, beyond_limits_n;
    logic [12:0] regAddr;
    logic [7:0] regWrData, regRdData, sensorTemp, tempReq, pressLen, v;
    logic [15:0] readCrc, crc;
    logic [31:0] seed;
    logic [7:0] expQ[$];
    logic [12:0] ro[6] = '{13'h0020, 13'h0060, 13'h0280, 13'h0880,
        13'h1800, 13'h0220};
    logic [4:0] to[7] = '{5'h00, 5'h06, 5'h05, 5'h04, 5'h02, 5'h01, 5'h00};
    logic [7:0] tv[7] = '{8'h00, 8'h24, 8'h02, 8'h28, 8'h23, 8'h59, 8'h59};
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    tlc_logger #(.TICK_DIV(2), .HOLD_TICKS(4), .SEC_TICKS(8),
        .SERIAL_NUMBER(SER)) uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .interface_select(interface_select),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .readCrc(readCrc),
        .syncActive(syncActive), .asyncActive(asyncActive),
        .sensorTemp(sensorTemp), .start_button_n(start_button_n),
        .interrupt_n(interrupt_n), .within_limits_n(within_limits_n),
        .beyond_limits_n(beyond_limits_n));
    tlc_env_model env (.sys_clk(sys_clk), .tempReq(tempReq),
        .pressLen(pressLen), .pressGo(pressGo), .sensorTemp(sensorTemp),
        .start_button_n(start_button_n));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] crcb(input logic [15:0] c,
        input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `TLC_CRC_POLY : 16'h0);
        end
        return c;
    endfunction
    function automatic logic [12:0] ctl(input logic [4:0] o);
        return {`TLC_PG_CTRL, o};
    endfunction
    function automatic logic [12:0] binA(input logic [7:0] t);
        return 13'h0800 + 13'((($signed(t) + 80) / 4) * 2);
    endfunction
    task check(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task end_sim;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {regAddr, regWrData, regWr} <= {a, d, 1'b1};
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    // c set: e is queued for the monitor to check; v always gets the result
    task rd(input logic [12:0] a, input logic [7:0] e, input logic c);
        if (c) expQ.push_back(e);
        @(posedge sys_clk);
        {regAddr, regRd, rdChk} <= {a, 1'b1, c};
        @(posedge sys_clk);
        {regRd, rdChk} <= 2'b00;
        #1 v = regRdData;
    endtask
    task wmin;
        logic [7:0] m;
        rd(ctl(`TLC_OFF_MIN), 8'h00, 1'b0);
        m = v;
        for (int i = 0; i < 700 && v === m; i++) rd(ctl(`TLC_OFF_MIN), 0, 0);
        check("minute step", v !== m, 1'b1);
    endtask
    task press(input logic [7:0] n, input int w);
        @(posedge sys_clk);
        {pressLen, pressGo} <= {n, 1'b1};
        @(posedge sys_clk);
        pressGo <= 1'b0;
        repeat (w) @(posedge sys_clk);
        #1;
    endtask
    task int_is(input logic e);
        repeat (3) @(posedge sys_clk);
        #1 check("interrupt_n", interrupt_n, e);
    endtask
    always @(posedge sys_clk) begin
        if (rdLate) check("regRdData", regRdData, expQ.pop_front());
        rdLate <= regRd && rdChk;
    end
    // ceiling well above the four minute waits (three sampled) of the second run
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        {rst_b, interface_select, regWr, regRd, rdChk, rdLate, pressGo} = '0;
        {regAddr, regWrData, tempReq, pressLen, crc} = '0;
        seed = 32'h6DD4C36E;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1 check("idle outs", {interrupt_n, within_limits_n, beyond_limits_n,
            asyncActive, syncActive, regRdData}, 13'h1E00);
        check("crc", readCrc, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(13'h0040 + 13'(i), seed[7:0]);
            rd(13'h0040 + 13'(i), seed[7:0], 1'b1);
            crc = crcb(16'h0000, seed[7:0]);
        end
        check("crc", readCrc, crc);
        @(posedge sys_clk);
        interface_select <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 check("link", {syncActive, asyncActive}, 2'b10);
        rd(13'h0020, 8'h00, 1'b1);
        check("crc", readCrc, crc);
        foreach (ro[i]) begin
            seed = lfsr(seed);
            wr(ro[i], seed[7:0]);
            rd(ro[i], 8'h00, 1'b1);
        end
        wr(13'h0218, 8'hFF);
        for (int i = 0; i < 8; i++) rd(13'h0218 + 13'(i), SER[8*i +: 8], 1);
        wr(13'h005F, 8'h5C);
        rd(13'h005F, 8'h5C, 1'b1);
        wr(ctl(`TLC_OFF_CTRL), 8'h02);
        wr(ctl(`TLC_OFF_STAT), 8'h02);
        int_is(1'b0);
        wr(ctl(`TLC_OFF_CTRL), 8'h04);
        int_is(1'b1);
        wr(ctl(`TLC_OFF_STAT), 8'h04);
        int_is(1'b0);
        wr(ctl(`TLC_OFF_STAT), 8'h00);
        int_is(1'b1);
        foreach (to[i]) wr(ctl(to[i]), tv[i]);
        rd(ctl(`TLC_OFF_SEC), 8'h00, 1'b0);
        for (int i = 0; i < 40 && v === 8'h59; i++) rd(ctl(5'h00), 0, 0);
        rd(ctl(`TLC_OFF_DATE), 8'h29, 1'b1);
        rd(ctl(`TLC_OFF_MON), 8'h02, 1'b1);
        rd(ctl(`TLC_OFF_HOUR), 8'h00, 1'b1);
        rd(ctl(`TLC_OFF_MIN), 8'h00, 1'b1);
        wr(ctl(`TLC_OFF_CTRL), 8'h00);
        press(8'd40, 60);
        rd(ctl(`TLC_OFF_STAT), 8'h00, 1'b0);
        check("mission", v & 8'h30, 8'h00);
        wr(ctl(`TLC_OFF_CTRL), 8'h10);
        press(8'd3, 40);
        rd(ctl(`TLC_OFF_STAT), 8'h00, 1'b0);
        check("mission", v & 8'h30, 8'h00);
        press(8'd60, 50);
        check("pins", {within_limits_n, beyond_limits_n}, 2'b01);
        press(8'd0, 20);
        check("pins", {within_limits_n, beyond_limits_n}, 2'b11);
        rd(ctl(`TLC_OFF_STAT), 8'h00, 1'b0);
        check("mission", (v & 8'h30) != 8'h00, 1'b1);
        wr(ctl(`TLC_OFF_STAT), 8'h02);
        press(8'd60, 50);
        check("pins", {within_limits_n, beyond_limits_n}, 2'b10);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        wr(ctl(`TLC_OFF_THI), 8'h30);
        wr(ctl(`TLC_OFF_TLO), 8'h04);
        wr(ctl(`TLC_OFF_RATE), 8'h01);
        wr(ctl(`TLC_OFF_DLY_L), 8'h00);
        wr(ctl(`TLC_OFF_DLY_H), 8'h00);
        wr(ctl(`TLC_OFF_CTRL), 8'h02);
        wmin();
        @(posedge sys_clk);
        tempReq <= 8'h40;
        wr(ctl(`TLC_OFF_CMD), `TLC_CMD_START);
        wmin();
        int_is(1'b0);
        @(posedge sys_clk);
        tempReq <= 8'h10;
        wmin();
        @(posedge sys_clk);
        tempReq <= 8'h80;
        wmin();
        rd(ctl(`TLC_OFF_STAT), 8'h00, 1'b0);
        check("status", v & 8'h26, 8'h26);
        wr(13'h1000, 8'h55);
        rd(13'h1000, 8'h40, 1'b1);
        rd(13'h1001, 8'h10, 1'b1);
        rd(13'h1002, 8'hB0, 1'b1);
        rd(binA(8'h40), 8'h01, 1'b1);
        rd(binA(8'h40) + 13'h1, 8'h00, 1'b1);
        rd(binA(8'h10), 8'h01, 1'b1);
        rd(binA(8'hB0), 8'h01, 1'b1);
        repeat (4) @(posedge sys_clk);
        end_sim();
    end
endmodule
